// ===== logic/pts_converter.sv
// parallel to serial converter: strobe latch, two stage sync, busy, bit counter, 8-to-1 selector
// assumes the transmit clock, strobe and parallel byte are asynchronous pins sampled by i_sys_clk
`timescale 1ns/1ps
//
// Contract
// - reset clears the state (strobe synchroniser set high) and busy, serial clock and data before any strobe is accepted
// - detected strobe raises busy and sends held byte, one bit per transmit clock
// - serial clock is inverted transmit clock ANDed with shift-active
// - 8-to-1 selector by bit count: count n sends input bit n
// - bit counter advances by one on transmit clock rising edge when permitted
// - three-bit counter marks when the last bit has been sent
// - strobe caught in a level latch, then one clocked sync register
// - latch sets on strobe low, holds, clears on strobe high with shift-active
// - shift-active captures busy AND count not seven on transmit rising edge
// - counter increments only while shift-active is high, else holds
// - serial data is low whenever shift-active is low
// - first sync register copies the latch on transmit rising edge
module pts_converter #(
    parameter int unsigned DATA_W = pts_pkg::DATA_W,
    parameter int unsigned DEPTH = pts_pkg::FIFO_DEPTH
) (
    input wire logic i_sys_clk,                // system clock, 100 MHz
    input wire logic i_nrst,                   // synchronous reset, active low
    input wire logic i_tx_clk,                 // transmit clock pin, asynchronous
    input wire logic i_write_strobe_n,         // write strobe pin, active low pulse
    input wire logic [DATA_W-1:0] i_parallel_in, // parallel byte pins
    output logic o_busy,                       // busy flag
    output logic o_serial_clk,                 // gated inverted transmit clock
    output logic o_serial_data_out,            // serial data bit
    output logic o_write_ready                 // buffer can take another byte
);
    localparam int unsigned CW = pts_pkg::CNT_W;

    typedef struct packed {
        logic [pts_pkg::SYNC_STAGES-1:0] clk_sync;
        logic [pts_pkg::SYNC_STAGES-1:0] strb_sync;
        logic [DATA_W-1:0] data_meta;
        logic [DATA_W-1:0] data_sync;
        logic clk_prev;
        logic strobe_latch;
        logic latch_prev;
        logic strobe_sync;
        logic gate;
        logic busy;
        logic [CW-1:0] count;
        logic sclk;
        logic ser_bit;
    } pts_state_s;

    // idle image of the state: the strobe pin idles high, everything else low
    localparam pts_state_s ST_RST = '{
        clk_sync: '0,
        strb_sync: '1,
        data_meta: pts_pkg::DATA_RST,
        data_sync: pts_pkg::DATA_RST,
        clk_prev: 1'b0,
        strobe_latch: 1'b0,
        latch_prev: 1'b0,
        strobe_sync: 1'b0,
        gate: 1'b0,
        busy: 1'b0,
        count: pts_pkg::CNT_RST,
        sclk: 1'b0,
        ser_bit: 1'b0
    };

    // ------------------------------------------------------------
    // internal signals
    // ------------------------------------------------------------
    pts_state_s st_ff;
    pts_state_s nxt_st;
    logic tx_clk;
    logic tx_rise;
    logic strobe_low;
    logic [DATA_W-1:0] head;
    logic tx_low;
    logic latch_set;
    logic latch_clr;
    logic count_last;
    logic count_step;
    logic [CW-1:0] count_next;
    logic gate_next;
    logic gate_now;
    logic byte_done;
    logic busy_start;
    logic busy_hold_sync;
    logic busy_hold_gate;
    logic busy_hold_clk;
    logic sel_bit;

    // ------------------------------------------------------------
    // byte buffer
    // ------------------------------------------------------------
    // bytes are captured at the strobe; depth only matters if the host strobes while busy
    pts_fifo_if #(.W(DATA_W)) fifo_bus ();

    pts_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .bus(fifo_bus)
    );

    // ------------------------------------------------------------
    // pin sampling and edge finding
    // ------------------------------------------------------------
    // the transmit clock is a pin here: its edges are found two samples late
    assign tx_clk = st_ff.clk_sync[1];
    assign tx_low = !tx_clk;
    assign tx_rise = tx_clk && !st_ff.clk_prev;
    assign strobe_low = !st_ff.strb_sync[1];

    // ------------------------------------------------------------
    // strobe latch terms
    // ------------------------------------------------------------
    // set wins over clear, so a strobe is never lost
    assign latch_set = strobe_low;
    assign latch_clr = !strobe_low && st_ff.gate;

    // ------------------------------------------------------------
    // bit counter and shift-active
    // ------------------------------------------------------------
    assign count_last = (st_ff.count == pts_pkg::CNT_LAST);
    assign gate_next = st_ff.busy && !count_last;
    assign gate_now = tx_rise ? gate_next : st_ff.gate;
    // steps only while shift-active; the wrap leaves count zero for the next byte
    assign count_step = tx_rise && st_ff.gate;
    assign count_next = count_step ? (st_ff.count + pts_pkg::CNT_STEP) : st_ff.count;

    // ------------------------------------------------------------
    // busy flag product terms
    // ------------------------------------------------------------
    // each hold term takes over before the previous one lets go, so busy never glitches low
    assign busy_start = st_ff.strobe_latch && st_ff.strobe_sync && tx_low;
    assign busy_hold_sync = st_ff.busy && st_ff.strobe_sync;
    assign busy_hold_gate = st_ff.busy && st_ff.gate;
    assign busy_hold_clk = st_ff.busy && tx_clk;

    // ------------------------------------------------------------
    // byte buffer hand-off
    // ------------------------------------------------------------
    // an empty buffer reads as zero so the selector never sends stale bits
    assign head = fifo_bus.out_valid ? fifo_bus.out_data : pts_pkg::DATA_RST;
    // one byte per strobe: pushed as the latch first sets
    assign fifo_bus.in_valid = st_ff.strobe_latch && !st_ff.latch_prev;
    assign fifo_bus.in_data = st_ff.data_sync;
    // head byte retires when shift-active drops at the end of the byte
    assign byte_done = tx_rise && st_ff.gate && !gate_now;
    assign fifo_bus.out_ready = byte_done;

    // ------------------------------------------------------------
    // 8-to-1 selector
    // ------------------------------------------------------------
    // decoded like a sum of products: input bit n is picked by count n
    always_comb begin
        sel_bit = 1'b0;
        for (int unsigned i = 0; i < DATA_W; i++) begin
            if (count_next == CW'(i)) begin
                sel_bit = head[i];
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.clk_sync = {st_ff.clk_sync[0], i_tx_clk};
        nxt_st.strb_sync = {st_ff.strb_sync[0], i_write_strobe_n};
        nxt_st.data_meta = i_parallel_in;
        nxt_st.data_sync = st_ff.data_meta;
        nxt_st.clk_prev = tx_clk;
        nxt_st.latch_prev = st_ff.strobe_latch;

        if (latch_set) begin
            nxt_st.strobe_latch = 1'b1;
        end else if (latch_clr) begin
            nxt_st.strobe_latch = 1'b0;
        end

        if (tx_rise) begin
            nxt_st.strobe_sync = st_ff.strobe_latch;
        end
        nxt_st.gate = gate_now;
        nxt_st.count = count_next;

        // set in the low phase, held until the clock falls after shift-active drops
        nxt_st.busy = busy_start
            || busy_hold_sync
            || busy_hold_gate
            || busy_hold_clk;

        nxt_st.sclk = !nxt_st.clk_prev && nxt_st.gate;
        // gating forces a low while idle; bits come from the buffered head byte, not the live pins
        nxt_st.ser_bit = nxt_st.gate && sel_bit;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            // synchronous reset: the pin synchronisers refill within two clocks of release
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_busy = st_ff.busy;
    assign o_serial_clk = st_ff.sclk;
    assign o_serial_data_out = st_ff.ser_bit;
    assign o_write_ready = fifo_bus.in_ready;
endmodule

// ===== logic/pts_pkg.sv
// package for the parallel to serial converter
// assumes one system clock; all link signals are sampled by it
package pts_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W = 3;
    localparam int unsigned FIFO_DEPTH = 32;
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic [CNT_W-1:0] CNT_RST = 3'h0;
    localparam logic [CNT_W-1:0] CNT_STEP = 3'h1;
    localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam real SYS_CLK_NS = 10.0;
    localparam real LINK_CLK_NS = 125.0;
endpackage

// ===== logic/pts_fifo_if.sv
// valid/ready carrier between the converter and its byte buffer
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface pts_fifo_if #(
    parameter int unsigned W = 8
);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// ===== logic/pts_fifo.sv
// synchronous byte buffer with valid/ready on both sides
// assumes a single clock and synchronous active low reset
`timescale 1ns/1ps
module pts_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    input wire logic i_sys_clk, // system clock
    input wire logic i_nrst,    // synchronous reset, active low
    pts_fifo_if.buffer bus      // push and pop sides
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] level;
    } pts_fifo_s;

    pts_fifo_s st_ff;
    pts_fifo_s nxt_st;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic push;
    logic pop;

    assign bus.in_ready = (st_ff.level != (AW+1)'(DEPTH));
    assign bus.out_valid = (st_ff.level != '0);
    assign bus.out_data = mem_ff[st_ff.rd_ptr];
    assign push = bus.in_valid && bus.in_ready;
    assign pop = bus.out_valid && bus.out_ready;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wr_ptr = (st_ff.wr_ptr == AW'(DEPTH-1)) ? '0 : st_ff.wr_ptr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd_ptr = (st_ff.rd_ptr == AW'(DEPTH-1)) ? '0 : st_ff.rd_ptr + 1'b1;
        end
        nxt_st.level = st_ff.level + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
        if (push) begin
            mem_ff[st_ff.wr_ptr] <= bus.in_data;
        end
    end
endmodule

// ===== test/pts_monitor.sv
// port checker for the converter
// assumes it is bound to pts_converter and sees only its ports
`timescale 1ns/1ps
module pts_monitor (
    input wire logic i_sys_clk, // system clock
    input wire logic i_nrst, // reset, active low
    input wire logic o_busy, // busy flag
    input wire logic o_serial_clk, // gated clock
    input wire logic o_serial_data_out, // serial bit
    input wire logic o_write_ready // buffer room
);
    logic [3:0] pulses_ff;
    // serial clock pulses seen in one busy episode
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || $rose(o_busy)) pulses_ff <= 4'h0;
        else if ($rose(o_serial_clk)) pulses_ff <= pulses_ff + 4'h1;
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    idle_data_low_a: assert property (!o_busy |-> !o_serial_data_out)
        else $error("data high while idle");
    idle_clk_low_a: assert property (!o_busy |-> !o_serial_clk)
        else $error("serial clock while idle");
    eight_bits_a: assert property ($fell(o_busy) |-> pulses_ff == 4'h8)
        else $error("byte not eight bits");
    start_quiet_a: assert property ($rose(o_busy) |-> !o_serial_clk && !o_serial_data_out)
        else $error("busy rose with shift running");
    bit_stable_a: assert property ($rose(o_serial_clk) |=> $stable(o_serial_data_out) [*3])
        else $error("bit changed inside clock pulse");
    pulse_width_a: assert property (o_serial_clk [*8] |-> 1'b0)
        else $error("serial clock pulse too long");
    busy_hold_a: assert property ($rose(o_busy) |-> o_busy [*8])
        else $error("busy dropped early");
    reset_clear_a: assert property (@(posedge i_sys_clk) disable iff (1'b0)
        !i_nrst |=> !o_busy && !o_serial_clk && !o_serial_data_out && o_write_ready)
        else $error("outputs not cleared by reset");
    cover property ($rose(o_busy));
    cover property ($fell(o_busy));
    cover property ($rose(o_serial_clk) && o_serial_data_out);
endmodule
bind pts_converter pts_monitor u_mon (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .o_busy(o_busy),
    .o_serial_clk(o_serial_clk), .o_serial_data_out(o_serial_data_out), .o_write_ready(o_write_ready));

// ===== test/pts_rx_model.sv
// receiving device: collects serial bits on the gated clock
// assumes lsb first and a clock that idles low between bytes
`timescale 1ns/1ps
module pts_rx_model (
    input wire logic i_serial_clk, // gated clock
    input wire logic i_serial_data_out, // serial bit
    input wire logic i_clear, // drop collected bits
    output logic [7:0] o_rx_byte, // collected byte
    output logic [3:0] o_rx_bits // bits collected
);
    always @(posedge i_serial_clk or posedge i_clear) begin
        if (i_clear) begin
            o_rx_byte <= 8'h00;
            o_rx_bits <= 4'h0;
        end else begin
            o_rx_byte <= {i_serial_data_out, o_rx_byte[7:1]};
            o_rx_bits <= o_rx_bits + 4'h1;
        end
    end
endmodule

// ===== test/parallel_to_serial_converter_tb_top.sv
// bench: host tasks strobe bytes in, the receiver model collects them
// assumes a free running 125 ns transmit clock
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
    $display("Error %0t got %h exp %h", $time, (a), (b)); end end
module parallel_to_serial_converter_tb_top;
    logic i_sys_clk = 1'b0;
    logic i_tx_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic stb_n = 1'b1;
    // starts low so the first clear is a real edge for the receiver
    logic clr = 1'b0;
    logic [7:0] pin = 8'h00;
    logic busy, sclk, ser_bit, wr_rdy;
    logic [7:0] rx_byte;
    logic [3:0] rx_bits;
    int failures = 0;
    int tests_run = 0;
    always #5 i_sys_clk = ~i_sys_clk;
    always #62.5 i_tx_clk = ~i_tx_clk;
    pts_converter dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_tx_clk(i_tx_clk), .i_write_strobe_n(stb_n),
        .i_parallel_in(pin), .o_busy(busy), .o_serial_clk(sclk), .o_serial_data_out(ser_bit), .o_write_ready(wr_rdy));
    pts_rx_model rx (.i_serial_clk(sclk), .i_serial_data_out(ser_bit), .i_clear(clr), .o_rx_byte(rx_byte),
        .o_rx_bits(rx_bits));
    task automatic test_done();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wait_busy(input logic lvl);
        for (int n = 0; busy !== lvl; n++) begin
            if (n > 400) begin
                failures++;
                test_done();
            end
            @(negedge i_sys_clk);
        end
    endtask
    task automatic start_byte(input logic [7:0] b);
        @(posedge i_sys_clk);
        clr <= 1'b1;
        pin <= b;
        repeat (4) @(posedge i_sys_clk);
        clr <= 1'b0;
        stb_n <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        stb_n <= 1'b1;
        wait_busy(1'b1);
        `CHK(sclk, 1'b0)
    endtask
    task automatic send_byte(input logic [7:0] b);
        start_byte(b);
        wait_busy(1'b0);
        `CHK(rx_byte, b)
        `CHK(rx_bits, 4'h8)
    endtask
    task automatic t_bit_walk();
        for (int i = 0; i < 8; i++) send_byte(8'h01 << i);
    endtask
    task automatic t_back_to_back();
        send_byte(8'hff);
        send_byte(8'h00);
        send_byte(8'ha5);
        `CHK(wr_rdy, 1'b1)
    endtask
    task automatic t_mid_reset();
        start_byte(8'hc3);
        repeat (40) @(posedge i_sys_clk);
        i_nrst <= 1'b0;
        repeat (3) @(negedge i_sys_clk);
        `CHK({busy, sclk, ser_bit, wr_rdy}, 4'h1)
        @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        send_byte(8'h3c);
    endtask
    initial begin
        repeat (7) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        `CHK({busy, sclk, ser_bit, wr_rdy}, 4'h1)
        @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        t_bit_walk();
        t_back_to_back();
        t_mid_reset();
        test_done();
    end
endmodule
